// >>> bench/dtp_load_model.sv
// dtp_load_model: the loads hanging on the four pwm pins; they only watch.
// assumes pins = {second slave, second master, first slave, first master}.
module dtp_load_model (
    input wire logic clk, // system clock
    input wire logic reset_n, // async reset, active low
    input wire logic [3:0] pins, // pwm pins as the loads see them
    output logic [3:0][15:0] period, // clocks between two rising edges
    output logic [3:0][15:0] width, // clocks high before the last fall
    output logic [3:0][31:0] rise_at // cycle stamp of the last rise
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] now;
    logic [3:0] last;

    // edge timing per pin; stays passive, the loads never answer back
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            now <= 32'h0;
            last <= 4'h0;
            period <= '0;
            width <= '0;
            rise_at <= '0;
        end else begin
            now <= now + 32'h1;
            last <= pins;
            for (int i = 0; i < 4; i++) begin
                if (pins[i] && !last[i]) begin
                    period[i] <= 16'(now - rise_at[i]);
                    rise_at[i] <= now;
                end
                if (!pins[i] && last[i]) begin
                    width[i] <= 16'(now - rise_at[i]);
                end
            end
        end
    end
endmodule // dtp_load_model

// >>> bench/testbench.sv
// testbench: self-checking bench for the dual timer pwm block.
// assumes the plain register port, prescale 0 (one tick a clock) outside one t_dual step, 200 MHz.
module testbench;
    import dtp_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [4:0] reg_addr = 5'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic [1:0] pwm_out_first, pwm_out_second, cycle_match_irq;
    logic [3:0] pins;
    logic [3:0][15:0] period, width;
    logic [3:0][31:0] rise_at;
    int err_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    int irq_cnt = 0;
    localparam logic [4:0] M = DTP_A_CR_BASE0;
    localparam logic [4:0] S = DTP_A_CR_BASE1;

    assign pins = {pwm_out_second, pwm_out_first};
    // 200 MHz clock
    always #2.5 clk = ~clk;

    dtp_top dtp_top_i (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .pwm_out_first(pwm_out_first), .pwm_out_second(pwm_out_second),
        .cycle_match_irq(cycle_match_irq));
    dtp_load_model dtp_load_model_i (.clk(clk), .reset_n(reset_n), .pins(pins),
        .period(period), .width(width), .rise_at(rise_at));

    task automatic end_sim();
        if (err_count == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // hang guard, far above the few hundred cycles the scenarios need
    always @(posedge clk) begin
        cyc++;
        if (cyc == 6000) begin
            err_count++;
            end_sim();
        end
    end

    // master wrap pulses, counted to see the interval
    always @(posedge clk) begin
        if (cycle_match_irq[0] === 1'b1) begin
            irq_cnt <= irq_cnt + 1;
        end
    end

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        d = reg_rdata;
    endtask

    task automatic settle(input int n);
        repeat (n) @(negedge clk);
    endtask

    // bounded wait for a master wrap, so updates start early in a cycle
    task automatic wait_wrap();
        for (int i = 0; i < 100; i++) begin
            @(negedge clk);
            if (cycle_match_irq[0] === 1'b1) begin
                break;
            end
        end
    endtask

    task automatic t_reset();
        logic [15:0] d;
        check(32'(pins), 32'h0);
        rd(M + 5'h1, d);
        check(32'(d), 32'(DTP_CR_RST));
        rd(DTP_A_STAT0, d);
        check(32'(d), 32'(DTP_CNT_RST));
        rd(5'h1f, d);
        check(32'(d), 32'h0);
        wr(DTP_A_CTL0_0, 16'h0002); // default level high, still stopped
        settle(4);
        check(32'(pwm_out_first[0]), 32'h1);
        wr(DTP_A_CTL0_0, 16'h0000);
    endtask

    task automatic t_single();
        int n;
        logic [7:0] hi;
        logic [15:0] d;
        wr(M + 5'h0, 16'h0001);
        wr(M + 5'h1, 16'h0003);
        wr(DTP_A_CTL0_0, 16'h0080);
        settle(20);
        n = irq_cnt;
        settle(40);
        check(32'(irq_cnt - n), 32'd10);
        check(32'(period[0]), 32'd4);
        check(32'(width[0]), 32'd2);
        wr(M + 5'h0, 16'h0000);
        wr(M + 5'h1, 16'h000f);
        settle(60);
        check(32'(period[0]), 32'd16);
        check(32'(width[0]), 32'd15);
        wait_wrap();
        wr(M + 5'h0, 16'h0002);
        wr(M + 5'h1, 16'h000f);
        wr(M + 5'h0, 16'h0004); // rewritten before the update lands
        settle(60);
        check(32'(width[0]), 32'd11);
        wr(M + 5'h0, 16'h0005);
        wr(M + 5'h1, 16'h0005);
        settle(40);
        hi = 8'h0;
        repeat (24) begin
            @(negedge clk);
            hi = hi + 8'(pwm_out_first[0]);
        end
        check(32'(hi), 32'h0);
        wr(DTP_A_CTL0_0, 16'h0000);
        settle(3);
        check(32'(pwm_out_first[0]), 32'h0);
        rd(DTP_A_STAT0, d);
        check(32'(d), 32'h0);
    endtask

    task automatic t_dual();
        wr(S + 5'h0, 16'h0000);
        wr(S + 5'h1, 16'h0002);
        wr(S + 5'h2, 16'h0001);
        wr(S + 5'h3, 16'h0005);
        wr(DTP_A_CTL0_1, 16'h0081);
        settle(40);
        check(32'(period[1]), 32'd6);
        check(32'(period[3]), 32'd6);
        check(32'(width[1]), 32'd2);
        check(32'(width[3]), 32'd4);
        // prescale 1 doubles every count; second pin now rests high
        wr(DTP_A_CTL0_1, 16'h0185);
        settle(60);
        check(32'(period[1]), 32'd12);
        check(32'(period[3]), 32'd12);
        check(32'(width[1]), 32'd4);
        check(32'(width[3]), 32'd4);
        wr(DTP_A_CTL0_1, 16'h0000);
    endtask

    task automatic t_sync_start();
        wr(M + 5'h0, 16'h0002);
        wr(M + 5'h1, 16'h0009);
        wr(DTP_A_CTL0_1, 16'h0001); // slave dual, run left to the master bit
        wr(DTP_A_MODE, 16'h0081);
        settle(50);
        check(32'(period[0]), 32'd10);
        check(32'(width[0]), 32'd7);
        check(32'(period[1]), 32'd6);
        check(32'(width[3]), 32'd4);
        wr(DTP_A_MODE, 16'h0001);
        settle(4);
        check(32'(pins), 32'h0);
    endtask

    task automatic t_sync_clear();
        int k;
        wr(S + 5'h0, 16'h0002);
        wr(S + 5'h1, 16'h0004);
        wr(S + 5'h2, 16'h0006);
        wr(S + 5'h3, 16'h0008);
        wr(M + 5'h0, 16'h0001);
        wr(M + 5'h1, 16'h0009);
        wr(DTP_A_MODE, 16'h0083);
        settle(60);
        check(32'(period[0]), 32'd10);
        check(32'(period[1]), 32'd10);
        check(32'(period[3]), 32'd10);
        check(32'(width[1]), 32'd2);
        check(32'(width[3]), 32'd2);
        check((rise_at[1] + 32'd100 - rise_at[0]) % 32'd10, 32'd1);
        k = 0;
        repeat (20) begin
            @(negedge clk);
            k = k + int'(cycle_match_irq[1] & cycle_match_irq[0]);
        end
        check(32'(k), 32'd2);
        wr(DTP_A_MODE, 16'h0003);
        settle(4);
        check(32'(pins), 32'h0);
    endtask

    // main sequence
    initial begin
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        settle(2);
        t_reset();
        t_single();
        t_dual();
        t_sync_start();
        t_sync_clear();
        end_sim();
    end
endmodule // testbench

// >>> design/dtp_chan.sv
// dtp_chan: one 16-bit up counter with buffered compares and two pwm pins.
// assumes run, tick and trig_wr come from the top; sync modes are resolved
// there and arrive as ext_match / use_ext.
module dtp_chan
    import dtp_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic reset_n, // async reset, active low
    input wire logic run, // counting allowed
    input wire logic tick, // count clock enable pulse
    input wire dtp_pkg::dtp_cfg_t cfg, // output config
    input wire dtp_pkg::dtp_cr_set_t cr_w, // compare values as written
    input wire logic trig_wr, // trigger register written
    input wire logic use_ext, // period comes from master
    input wire logic ext_match, // master cycle match
    output dtp_pkg::dtp_stat_t stat // state seen by the top
);
    typedef struct packed {
        logic [15:0] cnt;
        dtp_cr_set_t act;
        logic pending;
        logic [1:0] age;
        logic [1:0] pwm;
        logic match;
    } dtp_ch_st_t;

    dtp_ch_st_t s_q, s_d;
    logic [15:0] per;
    logic own_match, cyc;

    // toggle point: the next count reaches compare + 1, so the pin flips with it
    function automatic logic hit(input logic [15:0] c, input logic [15:0] v);
        return c == v;
    endfunction

    assign per = cfg.dual ? s_q.act.cr[3] : s_q.act.cr[1];
    // gated by run so a stopped timer with period 0 raises no match
    assign own_match = run && tick && s_q.cnt == per;
    assign cyc = use_ext ? ext_match : own_match;

    // next state
    always_comb begin
        s_d = s_q;
        s_d.match = 1'b0;
        if (!run) begin
            s_d.cnt = DTP_CNT_RST;
            s_d.pwm = {cfg.lvl1, cfg.lvl0};
            s_d.pending = 1'b0;
            // compares written before start are live from the first count
            s_d.act = cr_w;
        end else begin
            if (trig_wr) begin
                s_d.pending = 1'b1;
                s_d.age = 2'h0;
            end else if (s_q.pending && tick && s_q.age != 2'(DTP_LATE_TICKS + 1)) begin
                s_d.age = s_q.age + 2'h1;
            end
            if (tick) begin
                s_d.cnt = cyc ? DTP_CNT_RST : s_q.cnt + 16'h0001;
                s_d.match = cyc;
                // first pin on regs 0/1, second on 2/3, equal pair holds default
                if (s_q.act.cr[0] != s_q.act.cr[1] &&
                    (hit(s_q.cnt, s_q.act.cr[0]) || hit(s_q.cnt, s_q.act.cr[1]))) begin
                    s_d.pwm[0] = ~s_q.pwm[0];
                end
                if (cfg.dual && s_q.act.cr[2] != s_q.act.cr[3] &&
                    (hit(s_q.cnt, s_q.act.cr[2]) || hit(s_q.cnt, s_q.act.cr[3]))) begin
                    s_d.pwm[1] = ~s_q.pwm[1];
                end
                if (cyc) begin
                    // cycle restart: outputs back to default before next toggle
                    s_d.pwm = {cfg.lvl1, cfg.lvl0};
                    // late write (within two ticks) waits one more cycle
                    if (s_q.pending && s_q.age >= 2'(DTP_LATE_TICKS)) begin
                        s_d.act = cr_w;
                        s_d.pending = trig_wr;
                    end
                end
            end
        end
    end

    // state register
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_q <= '{cnt: DTP_CNT_RST, act: {4{DTP_CR_RST}}, pending: 1'b0,
                     age: 2'h0, pwm: 2'h0, match: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    // match is the wrap of this tick, so a slave can clear on the same edge
    assign stat = '{pwm: s_q.pwm, cnt: s_q.cnt, match: cyc, pending: s_q.pending};

    // count wraps exactly on its own period
    wrap_clear_a: assert property (@(posedge clk) disable iff (!reset_n)
        (run && !use_ext && own_match) |=> s_q.cnt == 16'h0000)
        else $error("counter not cleared on match");
    stop_clear_a: assert property (@(posedge clk) disable iff (!reset_n)
        !run |=> s_q.cnt == 16'h0000 && s_q.pwm == $past({cfg.lvl1, cfg.lvl0}))
        else $error("stopped channel not at rest");
    equal_fixed_a: assert property (@(posedge clk) disable iff (!reset_n)
        (run && s_q.act.cr[0] == s_q.act.cr[1] && !s_q.match && $stable(s_q.act))
        |=> $stable(s_q.pwm[0]) || s_q.match)
        else $error("equal compares toggled output");
    load_on_match_a: assert property (@(posedge clk) disable iff (!reset_n)
        ($past(run) && !$stable(s_q.act)) |-> s_q.match && $past(s_q.pending))
        else $error("compare set changed outside match");
    toggle_point_a: assert property (@(posedge clk) disable iff (!reset_n)
        (run && tick && !cyc && hit(s_q.cnt, s_q.act.cr[0])
         && s_q.act.cr[0] != s_q.act.cr[1]) |=> s_q.pwm[0] != $past(s_q.pwm[0]))
        else $error("first pin missed toggle");
    cover_update_c: cover property (@(posedge clk) disable iff (!reset_n)
        s_q.pending ##[1:300] !$stable(s_q.act));
endmodule // dtp_chan

// >>> design/dtp_top.sv
// Behaviour
// - single mode loads toggle and period, bit 7 of control zero starts first pin
// - single period is period register plus one count clocks
// - outputs invert when counter reaches compare plus one
// - new compares apply at first match, one later if written within two ticks
// - latest written compare values apply at the update
// - equal compare pair holds output at its default level
// - dual mode, pin one on regs 0/1, pin two on 2/3, reg 3 period
// - dual period is register 3 plus one count clocks
// - sync start, master mode bit 7 starts and stops both timers
// - sync clear, all outputs share one cycle run by master bit 7
// - sync clear period is master period register plus one
// - sync clear dual slave second pin uses slave regs 2 and 3
// - sync clear master period write last triggers update at master match
// - counter matching period clears to zero and raises cycle match
// - clearing count enable stops and clears the counter
//
// dtp_top: two pwm timers, master and slave, behind a plain register port.
// assumes a single 200 MHz clock; reads return data the cycle after strobe.
module dtp_top
    import dtp_pkg::*;
#(
    parameter int PRE_W = DTP_PRE_W // count clock prescaler width
) (
    input wire logic clk, // 200 MHz clock
    input wire logic reset_n, // async reset, active low
    input wire logic [4:0] reg_addr, // register index
    input wire logic [15:0] reg_wdata, // write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    output logic [15:0] reg_rdata, // read data, one cycle later
    output logic [1:0] pwm_out_first, // first pin of master, slave
    output logic [1:0] pwm_out_second, // second pin of master, slave
    output logic [1:0] cycle_match_irq // cycle match pulse per timer
);
    // refuse any prescaler width other than the package DTP_PRE_W
    if (PRE_W != DTP_PRE_W) begin : gen_bad_pre
        $error("prescaler width must match package");
    end

    typedef struct packed {
        logic [1:0][15:0] ctl0;
        logic [15:0] mode;
        logic [1:0][3:0][15:0] cr;
        logic [1:0][DTP_PRE_W-1:0] div;
        logic [15:0] rdata;
        logic [1:0] p1, p2, irq;
    } dtp_top_st_t;

    dtp_top_st_t s_q, s_d;
    dtp_stat_t [1:0] st;
    logic [1:0] run, tick, trig, ext;
    dtp_mode_t md;
    logic sync_en;

    // index of a compare write, or 3'h7 when none
    function automatic logic [2:0] cr_sel(input logic [4:0] a, input logic [4:0] b);
        return (a >= b && a < b + 5'h04) ? {1'b0, 2'(a - b)} : 3'h7;
    endfunction

    assign md = dtp_mode_t'(s_q.mode[DTP_B_MODE_LO +: 2]);
    assign sync_en = s_q.mode[DTP_B_RUN];

    // run and trigger decode per timer
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            run[i] = (md == DTP_M_ALONE) ? s_q.ctl0[i][DTP_B_RUN] : sync_en;
            tick[i] = s_q.div[i] == s_q.ctl0[i][DTP_B_PRE_LO +: DTP_PRE_W];
        end
        // sync clear shares the master count clock so both stay aligned
        if (md == DTP_M_SCLEAR) tick[1] = tick[0];
        // single mode triggers on reg 1, dual on reg 3
        trig[0] = reg_wr && cr_sel(reg_addr, DTP_A_CR_BASE0)
                  == (s_q.ctl0[0][DTP_B_DUAL] ? 3'h3 : 3'h1);
        trig[1] = reg_wr && cr_sel(reg_addr, DTP_A_CR_BASE1)
                  == (s_q.ctl0[1][DTP_B_DUAL] ? 3'h3 : 3'h1);
        // sync clear: master period reg write triggers both
        if (md == DTP_M_SCLEAR) trig[1] = trig[0];
        ext[0] = 1'b0;
        ext[1] = md == DTP_M_SCLEAR;
    end

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : gen_ch
            dtp_cfg_t cfg;
            assign cfg = '{dual: s_q.ctl0[g][DTP_B_DUAL], lvl0: s_q.ctl0[g][DTP_B_LVL0],
                           lvl1: s_q.ctl0[g][DTP_B_LVL1], pre: '0};
            dtp_chan u_ch (
                .clk(clk),
                .reset_n(reset_n),
                .run(run[g]),
                .tick(tick[g]),
                .cfg(cfg),
                .cr_w('{cr: s_q.cr[g]}),
                .trig_wr(trig[g]),
                .use_ext(ext[g]),
                // master never follows an outside match; avoids a loop on itself
                .ext_match(g == 0 ? 1'b0 : st[0].match),
                .stat(st[g])
            );
        end
    endgenerate

    // register writes, reads, prescalers and output staging
    always_comb begin
        logic [2:0] k0, k1;
        s_d = s_q;
        k0 = cr_sel(reg_addr, DTP_A_CR_BASE0);
        k1 = cr_sel(reg_addr, DTP_A_CR_BASE1);
        for (int i = 0; i < 2; i++) begin
            s_d.div[i] = (!run[i] || tick[i]) ? '0 : s_q.div[i] + 1'b1;
        end
        if (reg_wr) begin
            if (reg_addr == DTP_A_CTL0_0) s_d.ctl0[0] = reg_wdata;
            if (reg_addr == DTP_A_CTL0_1) s_d.ctl0[1] = reg_wdata;
            if (reg_addr == DTP_A_MODE) s_d.mode = reg_wdata;
            if (k0 != 3'h7) s_d.cr[0][k0[1:0]] = reg_wdata;
            if (k1 != 3'h7) s_d.cr[1][k1[1:0]] = reg_wdata;
        end
        s_d.rdata = 16'h0000;
        if (reg_rd) begin
            unique case (1'b1)
                reg_addr == DTP_A_CTL0_0: s_d.rdata = s_q.ctl0[0];
                reg_addr == DTP_A_CTL0_1: s_d.rdata = s_q.ctl0[1];
                reg_addr == DTP_A_MODE: s_d.rdata = s_q.mode;
                k0 != 3'h7: s_d.rdata = s_q.cr[0][k0[1:0]];
                k1 != 3'h7: s_d.rdata = s_q.cr[1][k1[1:0]];
                reg_addr == DTP_A_STAT0: s_d.rdata = st[0].cnt;
                reg_addr == DTP_A_STAT1: s_d.rdata = st[1].cnt;
                reg_addr == DTP_A_MATCH: s_d.rdata = {10'h000, st[1].pending,
                    st[0].pending, st[1].pwm, st[0].pwm};
                default: s_d.rdata = 16'h0000; // unmapped reads zero
            endcase
        end
        s_d.p1 = {st[1].pwm[0], st[0].pwm[0]};
        // second pin only meaningful in dual mode; otherwise held at default
        s_d.p2 = {st[1].pwm[1], st[0].pwm[1]};
        s_d.irq = {st[1].match, st[0].match};
    end

    // state register
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_q <= '{ctl0: '0, mode: 16'h0000, cr: {8{DTP_CR_RST}}, div: '0,
                     rdata: 16'h0000, p1: 2'h0, p2: 2'h0, irq: 2'h0};
        end else begin
            s_q <= s_d;
        end
    end

    assign reg_rdata = s_q.rdata;
    assign pwm_out_first = s_q.p1;
    assign pwm_out_second = s_q.p2;
    assign cycle_match_irq = s_q.irq;

    // sync modes start and stop both timers together
    sync_run_a: assert property (@(posedge clk) disable iff (!reset_n)
        md != DTP_M_ALONE |-> run[0] == run[1])
        else $error("timers not started together");
    shared_cycle_a: assert property (@(posedge clk) disable iff (!reset_n)
        (md == DTP_M_SCLEAR && $stable(md)) |-> st[1].match == st[0].match)
        else $error("slave cycle not on master match");
    irq_pulse_a: assert property (@(posedge clk) disable iff (!reset_n)
        st[0].match |=> cycle_match_irq[0])
        else $error("match not reported");
    read_latency_a: assert property (@(posedge clk) disable iff (!reset_n)
        (reg_rd && reg_addr == DTP_A_MODE) |=> reg_rdata == $past(s_q.mode))
        else $error("read data wrong");
    cover_single_c: cover property (@(posedge clk) disable iff (!reset_n)
        md == DTP_M_ALONE && pwm_out_first[0] ##[1:300] !pwm_out_first[0]);
    cover_sclear_c: cover property (@(posedge clk) disable iff (!reset_n)
        md == DTP_M_SCLEAR && cycle_match_irq[0]);
    cover_dual_c: cover property (@(posedge clk) disable iff (!reset_n)
        s_q.ctl0[0][DTP_B_DUAL] && $rose(pwm_out_second[0]));
endmodule // dtp_top

// >>> pkg/dtp_pkg.sv
// dtp_pkg: register map, field positions, reset values and carrier types
// for the dual timer pwm block; shared by the top and the timer channel.
package dtp_pkg;
    localparam int DTP_CW = 16;
    // register indices on the plain port (byte offsets = 4 x index)
    localparam logic [4:0] DTP_A_CTL0_0 = 5'h00;
    localparam logic [4:0] DTP_A_CTL0_1 = 5'h01;
    localparam logic [4:0] DTP_A_MODE = 5'h02;
    localparam logic [4:0] DTP_A_CR_BASE0 = 5'h04;
    localparam logic [4:0] DTP_A_CR_BASE1 = 5'h08;
    localparam logic [4:0] DTP_A_STAT0 = 5'h0c;
    localparam logic [4:0] DTP_A_STAT1 = 5'h0d;
    localparam logic [4:0] DTP_A_MATCH = 5'h0e;
    // field positions
    localparam int DTP_B_RUN = 7;
    localparam int DTP_B_DUAL = 0;
    localparam int DTP_B_LVL0 = 1;
    localparam int DTP_B_LVL1 = 2;
    localparam int DTP_B_PRE_LO = 8;
    localparam int DTP_B_MODE_LO = 0;
    // reset values
    localparam logic [15:0] DTP_CR_RST = 16'hffff;
    localparam logic [15:0] DTP_CNT_RST = 16'h0000;
    localparam int DTP_PRE_W = 8;
    // write of the trigger register inside this many count ticks before the
    // match defers the update by one more cycle
    localparam int DTP_LATE_TICKS = 2;

    typedef enum logic [1:0] {
        DTP_M_ALONE = 2'b00,
        DTP_M_SSTART = 2'b01,
        DTP_M_SCLEAR = 2'b11
    } dtp_mode_t;

    typedef struct packed {
        logic [3:0][15:0] cr;
    } dtp_cr_set_t;

    typedef struct packed {
        logic dual;
        logic lvl0;
        logic lvl1;
        logic [DTP_PRE_W-1:0] pre;
    } dtp_cfg_t;

    typedef struct packed {
        logic [1:0] pwm;
        logic [15:0] cnt;
        logic match;
        logic pending;
    } dtp_stat_t;
endpackage : dtp_pkg
